// ===== inc/ptst_pkg.sv
// Notes on behaviour
// - client raises at most one mode request with sop
// - two-step request reports exit time on side bus
// - insertion overwrites timestamp field with exit time
// - correction adds residence time to correction field
// - checksum zeroed, fixed or kept; never both
// - client gives field offsets together with sop
// - two-step ignores one-step inputs, packet untouched
// - two-step exit time on wide/narrow bus with strobes
// - fingerprint returned unchanged with the valid strobe
// - exit equals entry plus pipeline plus extra latency
// - entry time sampled from clock at sop
// - new correction = old + residence + optional asymmetry
// - correction mode never inserts exit time
// - client drives ingress timestamp during sop cycle
// - asymmetry added only when apply input is set
// - time source advances every cycle, wide/narrow format
// - narrow-only build supports correction mode only
// - both formats: per-packet format select chooses
// - internal wide time; V1 select writes V1 stamp
// - wide time: seconds, wrapping nanoseconds, fraction
// - V1 stamp: 32-bit seconds, 32-bit nanoseconds
// - narrow time: 48-bit nanoseconds, 16-bit fraction
package ptst_pkg;
  localparam int DW = 64;
  localparam int OFF_W = 16;
  localparam int WIDX_W = OFF_W - 3;
  localparam int CLK_NS = 100;
  localparam int PIPE_CYC = 1;
  localparam logic [31:0] PIPE_LAT_NS = 32'(PIPE_CYC * CLK_NS);
  localparam logic [47:0] NS_PER_S = 48'h0000_3B9A_CA00;
  localparam logic [15:0] FRAC_SHIFT = 16'h0010;

  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] ns;
    logic [15:0] frac;
  } ptst_v2_t;
  typedef struct packed {
    logic [47:0] ns;
    logic [15:0] frac;
  } ptst_n64_t;
  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } ptst_v1_t;

  typedef enum logic [1:0] {M_NONE, M_TWO, M_INS, M_COR} ptst_mode_t;

  typedef struct packed {
    logic asym_apply;
    logic fmt_alt;
    logic csum_fix;
    logic csum_zero;
    ptst_mode_t mode;
  } ptst_ctrl_t;

  localparam logic CFG_ADDED = 1'b0;
  localparam logic CFG_ASYM = 1'b1;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OFFS = 8'h04;
  localparam logic [7:0] REG_ADDED = 8'h08;
  localparam logic [7:0] REG_ASYM = 8'h0C;
  localparam logic [7:0] REG_STAMP_LO = 8'h10;
  localparam logic [7:0] REG_STAMP_HI = 8'h14;
  localparam logic [7:0] REG_FPRINT = 8'h18;
  localparam logic [7:0] REG_COUNT = 8'h1C;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ones-complement sum with end-around carry
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[15:0] + {15'h0000, t[16]};
  endfunction : oc_add

  // checksum compensation for replacing old by new, four 16-bit lanes
  function automatic logic [15:0] csum_fold(input logic [15:0] acc, input logic [DW-1:0] old_w,
                                            input logic [DW-1:0] new_w);
    logic [15:0] a;
    a = acc;
    for (int i = 0; i < DW / 16; i++) begin
      a = oc_add(a, oc_add(old_w[i*16 +: 16], ~new_w[i*16 +: 16]));
    end
    return a;
  endfunction : csum_fold
endpackage : ptst_pkg

// ===== inc/ptst_if.sv
`timescale 1ns/1ns
interface ptst_if #(parameter int FPW = 8);
  import ptst_pkg::*;
  logic tx_valid;
  logic tx_sop;
  logic tx_eop;
  logic [DW-1:0] tx_data;
  logic req_two_step;
  logic req_insert;
  logic req_correct;
  logic [OFF_W-1:0] off_stamp;
  logic [OFF_W-1:0] off_corr;
  logic [OFF_W-1:0] off_csum;
  logic csum_zero;
  logic csum_fix;
  logic fmt_alt;
  ptst_v2_t ingress_wide;
  ptst_n64_t ingress_narrow;
  logic asym_apply;
  logic [FPW-1:0] req_fprint;
  logic exit_stamp_wide_valid;
  ptst_v2_t exit_stamp_wide_bus;
  logic [FPW-1:0] exit_stamp_wide_fprint;
  logic exit_stamp_narrow_valid;
  ptst_n64_t exit_stamp_narrow_bus;
  logic [FPW-1:0] exit_stamp_narrow_fprint;
  logic cfg_we;
  logic cfg_sel;
  logic [31:0] cfg_data;

  modport dev (
    input tx_valid, tx_sop, tx_eop, tx_data, req_two_step, req_insert, req_correct,
    input off_stamp, off_corr, off_csum, csum_zero, csum_fix, fmt_alt,
    input ingress_wide, ingress_narrow, asym_apply, req_fprint, cfg_we, cfg_sel, cfg_data,
    output exit_stamp_wide_valid, exit_stamp_wide_bus, exit_stamp_wide_fprint,
    output exit_stamp_narrow_valid, exit_stamp_narrow_bus, exit_stamp_narrow_fprint
  );
  modport cli (
    output tx_valid, tx_sop, tx_eop, tx_data, req_two_step, req_insert, req_correct,
    output off_stamp, off_corr, off_csum, csum_zero, csum_fix, fmt_alt,
    output ingress_wide, ingress_narrow, asym_apply, req_fprint, cfg_we, cfg_sel, cfg_data,
    input exit_stamp_wide_valid, exit_stamp_wide_bus, exit_stamp_wide_fprint,
    input exit_stamp_narrow_valid, exit_stamp_narrow_bus, exit_stamp_narrow_fprint
  );
endinterface : ptst_if

// ===== rtl/ptst_exit_calc.sv
`timescale 1ns/1ns
module ptst_exit_calc
  import ptst_pkg::*;
(
  input wire ptst_v2_t tod_wide,
  input wire ptst_n64_t tod_narrow,
  input wire logic [31:0] delta_ns,
  output ptst_v2_t exit_wide,
  output ptst_n64_t exit_narrow
);
  logic [32:0] ns_sum;

  // delta stays far below one second, so one wrap step is enough
  always_comb begin
    ns_sum = {1'b0, tod_wide.ns} + {1'b0, delta_ns};
    exit_wide = tod_wide;
    if (48'(ns_sum) >= NS_PER_S) begin
      exit_wide.ns = 32'(48'(ns_sum) - NS_PER_S);
      exit_wide.sec = tod_wide.sec + 48'h1;
    end else begin
      exit_wide.ns = ns_sum[31:0];
    end
    exit_narrow = tod_narrow + (64'(delta_ns) << FRAC_SHIFT);
  end
endmodule : ptst_exit_calc

// ===== rtl/ptst_dev.sv
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module ptst_dev
  import ptst_pkg::*;
#(
  parameter int FPW = 8,
  parameter bit HAS_WIDE = 1'b1,
  parameter bit HAS_NARROW = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  ptst_if.dev lk,
  input wire ptst_v2_t send_side_clock_wide,
  input wire ptst_n64_t send_side_clock_narrow,
  output logic link_valid,
  output logic link_sop,
  output logic link_eop,
  output logic [DW-1:0] link_data
);
  typedef struct packed {
    logic [31:0] added_delay_setting;
    logic [31:0] asymmetry_delay_setting;
    ptst_mode_t mode;
    logic fmt_alt;
    logic asym_on;
    logic csum_zero;
    logic csum_fix;
    logic [WIDX_W-1:0] f_idx;
    logic [OFF_W-1:0] cs_off;
    ptst_v2_t exit_w;
    logic [DW-1:0] res;
    logic [WIDX_W-1:0] widx;
    logic [15:0] acc;
    logic out_valid;
    logic out_sop;
    logic out_eop;
    logic [DW-1:0] out_data;
    logic w_valid;
    ptst_v2_t w_bus;
    logic [FPW-1:0] w_fp;
    logic n_valid;
    ptst_n64_t n_bus;
    logic [FPW-1:0] n_fp;
  } ptst_dev_t;

  ptst_dev_t s;
  ptst_dev_t next_s;
  ptst_v2_t exit_w;
  ptst_n64_t exit_n;
  logic [DW-1:0] d;
  logic [47:0] rns;
  logic [1:0] lane;
  logic narrow_sel;

  // the extra latency is taken at sop together with the entry time
  ptst_exit_calc u_calc (
    .tod_wide(send_side_clock_wide),
    .tod_narrow(send_side_clock_narrow),
    .delta_ns(PIPE_LAT_NS + s.added_delay_setting),
    .exit_wide(exit_w),
    .exit_narrow(exit_n)
  );

  always_comb begin
    next_s = s;
    d = lk.tx_data;
    rns = '0;
    lane = s.cs_off[2:1];
    narrow_sel = 1'b0;
    next_s.w_valid = 1'b0;
    next_s.n_valid = 1'b0;
    next_s.out_valid = lk.tx_valid;
    next_s.out_sop = lk.tx_valid && lk.tx_sop;
    next_s.out_eop = lk.tx_valid && lk.tx_eop;
    if (lk.cfg_we) begin
      if (lk.cfg_sel == CFG_ASYM) begin
        next_s.asymmetry_delay_setting = lk.cfg_data;
      end else begin
        next_s.added_delay_setting = lk.cfg_data;
      end
    end
    if (lk.tx_valid && lk.tx_sop) begin
      next_s.widx = WIDX_W'(1);
      next_s.acc = '0;
      // narrow-only builds have no wide time, so only correction remains
      if (lk.req_two_step && HAS_WIDE) begin
        next_s.mode = M_TWO;
      end else if (lk.req_insert && HAS_WIDE) begin
        next_s.mode = M_INS;
      end else if (lk.req_correct) begin
        next_s.mode = M_COR;
      end else begin
        next_s.mode = M_NONE;
      end
      narrow_sel = HAS_NARROW && (!HAS_WIDE || lk.fmt_alt);
      next_s.fmt_alt = (next_s.mode == M_COR) ? narrow_sel : lk.fmt_alt;
      next_s.f_idx = (next_s.mode == M_INS) ? lk.off_stamp[OFF_W-1:3] : lk.off_corr[OFF_W-1:3];
      next_s.cs_off = lk.off_csum;
      next_s.asym_on = lk.asym_apply;
      next_s.csum_zero = lk.csum_zero && (next_s.mode inside {M_INS, M_COR});
      next_s.csum_fix = lk.csum_fix && (next_s.mode inside {M_INS, M_COR});
      next_s.exit_w = exit_w;
      if (narrow_sel) begin
        next_s.res = exit_n - lk.ingress_narrow;
      end else begin
        rns = (exit_w.sec - lk.ingress_wide.sec) * NS_PER_S + 48'(exit_w.ns)
              - 48'(lk.ingress_wide.ns);
        next_s.res = {rns, exit_w.frac} - 64'(lk.ingress_wide.frac);
      end
      if (next_s.mode == M_TWO) begin
        next_s.w_valid = HAS_WIDE;
        next_s.w_bus = exit_w;
        next_s.w_fp = lk.req_fprint;
        next_s.n_valid = HAS_NARROW;
        next_s.n_bus = exit_n;
        next_s.n_fp = lk.req_fprint;
      end
    end else if (lk.tx_valid) begin
      next_s.widx = s.widx + WIDX_W'(1);
      if (s.mode == M_INS) begin
        if (s.widx == s.f_idx) begin
          if (s.fmt_alt) begin
            d = {s.exit_w.sec[31:0], s.exit_w.ns};
          end else begin
            d = {s.exit_w.sec, s.exit_w.ns[31:16]};
          end
        end else if (s.widx == s.f_idx + WIDX_W'(1) && !s.fmt_alt) begin
          d = {s.exit_w.ns[15:0], lk.tx_data[47:0]};
        end
      end else if (s.mode == M_COR && s.widx == s.f_idx) begin
        // exit time feeds only the residence sum here
        d = lk.tx_data + s.res;
        if (s.asym_on) begin
          d = d + (64'(s.asymmetry_delay_setting) << FRAC_SHIFT);
        end
      end
      if (s.csum_zero && s.widx == s.cs_off[OFF_W-1:3]) begin
        d = d & ~({48'h0000_0000_0000, 16'hFFFF} << ((2'h3 - lane) * FRAC_SHIFT));
      end
      if (s.csum_fix) begin
        // compensation lands in the last two bytes, reserved by the client
        next_s.acc = csum_fold(s.acc, lk.tx_data, d);
        if (lk.tx_eop) begin
          d[15:0] = oc_add(d[15:0], next_s.acc);
        end
      end
    end
    next_s.out_data = d;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link_valid = s.out_valid;
  assign link_sop = s.out_sop;
  assign link_eop = s.out_eop;
  assign link_data = s.out_data;
  assign lk.exit_stamp_wide_valid = s.w_valid;
  assign lk.exit_stamp_wide_bus = s.w_bus;
  assign lk.exit_stamp_wide_fprint = s.w_fp;
  assign lk.exit_stamp_narrow_valid = s.n_valid;
  assign lk.exit_stamp_narrow_bus = s.n_bus;
  assign lk.exit_stamp_narrow_fprint = s.n_fp;
endmodule : ptst_dev

// ===== rtl/ptst_host.sv
`timescale 1ns/1ns
module ptst_host
  import ptst_pkg::*;
#(
  parameter int FPW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  ptst_if.cli lk,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic u_valid,
  input wire logic u_sop,
  input wire logic u_eop,
  input wire logic [DW-1:0] u_data,
  input wire ptst_v2_t u_ingress_wide,
  input wire ptst_n64_t u_ingress_narrow
);
  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    ptst_ctrl_t ctrl;
    logic [31:0] offs;
    logic [31:0] added;
    logic [31:0] asym;
    logic [DW-1:0] stamp;
    logic [FPW-1:0] fp_last;
    logic [31:0] count;
    logic [FPW-1:0] fp_next;
    logic [31:0] rdata;
    logic ready;
    logic tx_valid;
    logic tx_sop;
    logic tx_eop;
    logic [DW-1:0] tx_data;
    logic req_two;
    logic req_ins;
    logic req_cor;
    ptst_v2_t ing_w;
    ptst_n64_t ing_n;
    logic [FPW-1:0] fprint;
    logic cfg_we;
    logic cfg_sel;
    logic [31:0] cfg_data;
  } ptst_host_t;

  ptst_host_t s;
  ptst_host_t next_s;

  always_comb begin
    next_s = s;
    next_s.ready = 1'b1;
    next_s.cfg_we = 1'b0;
    next_s.ap_valid = hsel && hready && htrans == HTRANS_NONSEQ;
    next_s.ap_write = hwrite;
    next_s.ap_addr = haddr[7:0];
    if (s.ap_valid && s.ap_write) begin
      unique case (s.ap_addr)
        REG_CTRL: next_s.ctrl = ptst_ctrl_t'(hwdata[$bits(ptst_ctrl_t)-1:0]);
        REG_OFFS: next_s.offs = hwdata;
        REG_ADDED: begin
          next_s.added = hwdata;
          next_s.cfg_we = 1'b1;
          next_s.cfg_sel = CFG_ADDED;
          next_s.cfg_data = hwdata;
        end
        REG_ASYM: begin
          next_s.asym = hwdata;
          next_s.cfg_we = 1'b1;
          next_s.cfg_sel = CFG_ASYM;
          next_s.cfg_data = hwdata;
        end
        default: ;
      endcase
    end
    // read data is fetched in the address phase: zero wait states
    if (next_s.ap_valid && !hwrite) begin
      unique case (haddr[7:0])
        REG_CTRL: next_s.rdata = 32'(s.ctrl);
        REG_OFFS: next_s.rdata = s.offs;
        REG_ADDED: next_s.rdata = s.added;
        REG_ASYM: next_s.rdata = s.asym;
        REG_STAMP_LO: next_s.rdata = s.stamp[31:0];
        REG_STAMP_HI: next_s.rdata = s.stamp[63:32];
        REG_FPRINT: next_s.rdata = 32'(s.fp_last);
        REG_COUNT: next_s.rdata = s.count;
        default: next_s.rdata = '0;
      endcase
    end
    next_s.tx_valid = u_valid;
    next_s.tx_sop = u_valid && u_sop;
    next_s.tx_eop = u_valid && u_eop;
    next_s.tx_data = u_data;
    next_s.req_two = 1'b0;
    next_s.req_ins = 1'b0;
    next_s.req_cor = 1'b0;
    if (u_valid && u_sop) begin
      next_s.req_two = s.ctrl.mode == M_TWO;
      next_s.req_ins = s.ctrl.mode == M_INS;
      next_s.req_cor = s.ctrl.mode == M_COR;
      next_s.ing_w = u_ingress_wide;
      next_s.ing_n = u_ingress_narrow;
      next_s.fprint = s.fp_next;
      next_s.fp_next = s.fp_next + FPW'(1);
    end
    if (lk.exit_stamp_narrow_valid) begin
      next_s.stamp = lk.exit_stamp_narrow_bus;
      next_s.fp_last = lk.exit_stamp_narrow_fprint;
      next_s.count = s.count + 32'h1;
    end else if (lk.exit_stamp_wide_valid) begin
      next_s.stamp = {lk.exit_stamp_wide_bus.sec[31:0], lk.exit_stamp_wide_bus.ns};
      next_s.fp_last = lk.exit_stamp_wide_fprint;
      next_s.count = s.count + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.ready;
  assign hrdata = s.rdata;
  assign hresp = 1'b0;
  assign lk.tx_valid = s.tx_valid;
  assign lk.tx_sop = s.tx_sop;
  assign lk.tx_eop = s.tx_eop;
  assign lk.tx_data = s.tx_data;
  assign lk.req_two_step = s.req_two;
  assign lk.req_insert = s.req_ins;
  assign lk.req_correct = s.req_cor;
  assign lk.off_stamp = s.offs[OFF_W-1:0];
  assign lk.off_corr = s.offs[OFF_W-1:0];
  assign lk.off_csum = s.offs[31:OFF_W];
  assign lk.csum_zero = s.ctrl.csum_zero && !s.ctrl.csum_fix;
  assign lk.csum_fix = s.ctrl.csum_fix;
  assign lk.fmt_alt = s.ctrl.fmt_alt;
  assign lk.ingress_wide = s.ing_w;
  assign lk.ingress_narrow = s.ing_n;
  assign lk.asym_apply = s.ctrl.asym_apply;
  assign lk.req_fprint = s.fprint;
  assign lk.cfg_we = s.cfg_we;
  assign lk.cfg_sel = s.cfg_sel;
  assign lk.cfg_data = s.cfg_data;
endmodule : ptst_host

// ===== bench/ptst_properties.sv
`timescale 1ns/1ns
module ptst_properties
  import ptst_pkg::*;
#(
  parameter int FPW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tx_valid,
  input wire logic tx_sop,
  input wire logic req_two_step,
  input wire logic req_insert,
  input wire logic req_correct,
  input wire logic [FPW-1:0] req_fprint,
  input wire logic exit_stamp_wide_valid,
  input wire ptst_v2_t exit_stamp_wide_bus,
  input wire logic [FPW-1:0] exit_stamp_wide_fprint,
  input wire logic exit_stamp_narrow_valid,
  input wire logic [FPW-1:0] exit_stamp_narrow_fprint
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_two;
    tx_valid && tx_sop && req_two_step;
  endsequence
  sequence s_any_req;
    req_two_step || req_insert || req_correct;
  endsequence
  chk_wide_strobe_due: assert property (s_two |=> exit_stamp_wide_valid)
    else $error("wide strobe missing");
  chk_narrow_strobe_due: assert property (s_two |=> exit_stamp_narrow_valid)
    else $error("narrow strobe missing");
  chk_wide_strobe_cause: assert property (exit_stamp_wide_valid |->
    $past(tx_valid && tx_sop && req_two_step)) else $error("wide strobe without request");
  chk_narrow_strobe_cause: assert property (exit_stamp_narrow_valid |->
    $past(tx_valid && tx_sop && req_two_step)) else $error("narrow strobe without request");
  chk_wide_fprint_echo: assert property (s_two |=>
    exit_stamp_wide_fprint == $past(req_fprint)) else $error("wide fingerprint changed");
  chk_narrow_fprint_echo: assert property (s_two |=>
    exit_stamp_narrow_fprint == $past(req_fprint)) else $error("narrow fingerprint changed");
  chk_ns_below_wrap: assert property (exit_stamp_wide_valid |->
    exit_stamp_wide_bus.ns < NS_PER_S[31:0]) else $error("nanoseconds not wrapped");
  chk_single_mode_req: assert property (tx_valid && tx_sop |->
    $onehot0({req_two_step, req_insert, req_correct})) else $error("several modes at once");
  chk_req_at_sop: assert property (s_any_req |-> tx_valid && tx_sop)
    else $error("request outside start of packet");
endmodule : ptst_properties

// ===== bench/test_ptp_tx_timestamp_unit.sv
`timescale 1ns/1ns
module test_ptp_tx_timestamp_unit
  import ptst_pkg::*;
;
  logic clk, nrst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic u_valid, u_sop, u_eop, link_valid, link_sop, link_eop;
  logic [DW-1:0] u_data, link_data;
  ptst_v2_t u_ingress_wide, tod_w, sop_w, got_w;
  ptst_n64_t u_ingress_narrow, tod_n, sop_n, got_n;
  logic [DW-1:0] link_q[$];
  logic [1:0] flag_q[$];
  logic [DW-1:0] pkt[5];
  logic [DW-1:0] exp_d[5];
  int n_errors, samples_checked, cycles, n_strobe, pkt_n;

  ptst_if #(.FPW(8)) ptst_if_i ();
  ptst_host #(.FPW(8)) ptst_host_i (.clk(clk), .nrst(nrst), .lk(ptst_if_i.cli), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .u_valid(u_valid), .u_sop(u_sop), .u_eop(u_eop), .u_data(u_data),
    .u_ingress_wide(u_ingress_wide), .u_ingress_narrow(u_ingress_narrow));
  ptst_dev #(.FPW(8)) ptst_dev_i (.clk(clk), .nrst(nrst),
    .lk(ptst_if_i.dev), .send_side_clock_wide(tod_w), .send_side_clock_narrow(tod_n),
    .link_valid(link_valid), .link_sop(link_sop), .link_eop(link_eop), .link_data(link_data));
  ptst_properties #(.FPW(8)) ptst_properties_i (.clk(clk), .nrst(nrst),
    .tx_valid(ptst_if_i.tx_valid), .tx_sop(ptst_if_i.tx_sop),
    .req_two_step(ptst_if_i.req_two_step), .req_insert(ptst_if_i.req_insert),
    .req_correct(ptst_if_i.req_correct), .req_fprint(ptst_if_i.req_fprint),
    .exit_stamp_wide_valid(ptst_if_i.exit_stamp_wide_valid),
    .exit_stamp_wide_bus(ptst_if_i.exit_stamp_wide_bus),
    .exit_stamp_wide_fprint(ptst_if_i.exit_stamp_wide_fprint),
    .exit_stamp_narrow_valid(ptst_if_i.exit_stamp_narrow_valid),
    .exit_stamp_narrow_fprint(ptst_if_i.exit_stamp_narrow_fprint));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // time source steps one clock period per cycle; stamps and link words are captured here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (tod_w.ns + 32'h64 >= NS_PER_S[31:0]) begin
      tod_w.ns <= tod_w.ns + 32'h64 - NS_PER_S[31:0];
      tod_w.sec <= tod_w.sec + 48'h1;
    end else begin
      tod_w.ns <= tod_w.ns + 32'h64;
    end
    tod_n.ns <= tod_n.ns + 48'h64;
    if (ptst_if_i.tx_valid === 1'b1 && ptst_if_i.tx_sop === 1'b1) begin
      sop_w <= tod_w;
      sop_n <= tod_n;
    end
    if (link_valid === 1'b1) begin
      link_q.push_back(link_data);
      flag_q.push_back({link_sop, link_eop});
    end
    if (ptst_if_i.exit_stamp_wide_valid === 1'b1) begin
      got_w <= ptst_if_i.exit_stamp_wide_bus;
      got_n <= ptst_if_i.exit_stamp_narrow_bus;
      n_strobe <= n_strobe + 1;
    end
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  task chk(input logic [95:0] g, input logic [95:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one zero-wait single transfer, then an idle cycle so a read never meets a fresh write
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({95'h0, hresp}, 96'h0);
    @(posedge clk);
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0, r);
    chk({64'h0, r}, {64'h0, e});
  endtask : rd_chk

  task send(input int n);
    link_q.delete();
    flag_q.delete();
    pkt_n = n;
    for (int i = 0; i < n; i++) begin
      pkt[i] = 64'hA5C3_0000_0000_0000 + 64'(i) * 64'h0101_0101;
      exp_d[i] = pkt[i];
      u_valid <= 1'b1;
      u_sop <= (i == 0);
      u_eop <= (i == n - 1);
      u_data <= pkt[i];
      @(posedge clk);
    end
    u_valid <= 1'b0;
    u_sop <= 1'b0;
    u_eop <= 1'b0;
    for (int k = 0; k < 20 && link_q.size() < n; k++) @(posedge clk);
    @(posedge clk);
    chk(96'(link_q.size()), 96'(n));
  endtask : send

  task cmp(input int n);
    for (int i = 0; i < n && i < link_q.size(); i++) begin
      chk({32'h0, link_q[i]}, {32'h0, exp_d[i]});
      chk(96'(flag_q[i]), 96'({i == 0, i == pkt_n - 1}));
    end
  endtask : cmp

  function automatic ptst_v2_t exit_w(input ptst_v2_t t, input logic [31:0] d);
    ptst_v2_t r;
    logic [32:0] s;
    r = t;
    s = {1'b0, t.ns} + {1'b0, d};
    if (s >= {1'b0, NS_PER_S[31:0]}) begin
      s = s - {1'b0, NS_PER_S[31:0]};
      r.sec = t.sec + 48'h1;
    end
    r.ns = s[31:0];
    return r;
  endfunction : exit_w

  function automatic ptst_n64_t exit_n(input ptst_n64_t t, input logic [31:0] d);
    ptst_n64_t r;
    r = t;
    r.ns = t.ns + {16'h0000, d};
    return r;
  endfunction : exit_n

  task t_regs;
    rd_chk(REG_COUNT, 32'h0);
    wr(8'h20, 32'hDEAD_BEEF);
    rd_chk(8'h20, 32'h0);
    wr(REG_ADDED, 32'h0000_00FA);
    rd_chk(REG_ADDED, 32'h0000_00FA);
  endtask : t_regs

  task t_two_step;
    ptst_n64_t en;
    wr(REG_OFFS, 32'h0018_0010);
    wr(REG_CTRL, 32'h0000_000D); // checksum flags set but must be ignored
    send(3);
    cmp(3);
    chk(96'(n_strobe), 96'h1);
    chk(got_w, exit_w(sop_w, PIPE_LAT_NS + 32'hFA));
    en = exit_n(sop_n, PIPE_LAT_NS + 32'hFA);
    chk({32'h0, got_n}, {32'h0, en});
    rd_chk(REG_STAMP_LO, en[31:0]);
    rd_chk(REG_STAMP_HI, en[63:32]);
    rd_chk(REG_FPRINT, 32'h0);
    rd_chk(REG_COUNT, 32'h1);
  endtask : t_two_step

  task t_insert(input logic v1);
    ptst_v2_t ew;
    wr(REG_OFFS, 32'h0020_0010);
    wr(REG_CTRL, {27'h0, v1, 4'h6}); // insert with checksum zeroing
    send(5);
    ew = exit_w(sop_w, PIPE_LAT_NS + 32'hFA);
    if (v1) begin
      exp_d[2] = {ew.sec[31:0], ew.ns};
    end else begin
      exp_d[2] = {ew.sec, ew.ns[31:16]};
      exp_d[3] = {ew.ns[15:0], pkt[3][47:0]};
    end
    exp_d[4][63:48] = 16'h0000;
    cmp(5);
    chk(96'(n_strobe), 96'h1);
  endtask : t_insert

  task t_correct(input logic asym, input logic nar);
    ptst_n64_t en;
    ptst_v2_t ew;
    logic [47:0] r;
    logic [DW-1:0] res;
    wr(REG_ASYM, 32'h0000_0007);
    wr(REG_OFFS, 32'h0028_0008);
    wr(REG_CTRL, {26'h0, asym, nar, 4'h3}); // correction, narrow or wide residence
    u_ingress_narrow <= {48'h0000_1200_0000, 16'h1234};
    u_ingress_wide <= {48'h0001_0000_0005, 32'h3B9A_0000, 16'h8000};
    send(3);
    en = exit_n(sop_n, PIPE_LAT_NS + 32'hFA);
    ew = exit_w(sop_w, PIPE_LAT_NS + 32'hFA);
    // wide ingress lies one second back, so nanoseconds and fraction both borrow
    r = (ew.sec - u_ingress_wide.sec) * NS_PER_S + 48'(ew.ns) - 48'(u_ingress_wide.ns);
    res = nar ? en - u_ingress_narrow : {r, ew.frac} - 64'(u_ingress_wide.frac);
    exp_d[1] = pkt[1] + res + (asym ? 64'h0007_0000 : 64'h0);
    cmp(3);
    chk(96'(n_strobe), 96'h1);
  endtask : t_correct

  task t_csum_fix;
    ptst_v2_t ew;
    int si;
    int so;
    wr(REG_OFFS, 32'h0020_0010);
    wr(REG_CTRL, 32'h0000_000A); // insert with checksum compensation
    send(5);
    ew = exit_w(sop_w, PIPE_LAT_NS + 32'hFA);
    exp_d[2] = {ew.sec, ew.ns[31:16]};
    exp_d[3] = {ew.ns[15:0], pkt[3][47:0]};
    cmp(4);
    si = 0;
    so = 0;
    for (int i = 0; i < 5 && i < link_q.size(); i++) begin
      for (int k = 0; k < 4; k++) begin
        si += int'(pkt[i][k*16 +: 16]);
        so += int'(link_q[i][k*16 +: 16]);
      end
    end
    // compensation keeps the ones-complement sum, equal modulo 0xFFFF either zero form
    chk(96'(so % 65535), 96'(si % 65535));
    chk(96'(link_q[4][63:16]), 96'(pkt[4][63:16]));
  endtask : t_csum_fix

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    u_valid = 1'b0;
    u_sop = 1'b0;
    u_eop = 1'b0;
    u_data = 64'h0;
    u_ingress_wide = {48'h0000_0000_0003, 32'h0000_1000, 16'h0000};
    u_ingress_narrow = 64'h0;
    tod_w = {48'h0001_0000_0005, 32'h3B9A_C8D4, 16'h4321}; // near the nanosecond wrap
    tod_n = {48'h0000_1234_0000, 16'hABCD};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_two_step();
    t_insert(1'b0);
    t_insert(1'b1);
    t_correct(1'b0, 1'b1);
    t_correct(1'b1, 1'b1);
    t_correct(1'b1, 1'b0);
    t_csum_fix();
    close_out();
  end
endmodule : test_ptp_tx_timestamp_unit
